// [inc/tpq_pkg.sv]
package tpq_pkg;
   // ------------------------------------------------------------------
   // widths and constants
   // ------------------------------------------------------------------
   localparam int           CNT_W      = 16;
   localparam logic [15:0]  CNT_ALL1   = 16'hFFFF;
   localparam logic [15:0]  CNT_RST    = 16'h0000;
   localparam logic [15:0]  RELOAD_RST = 16'h0000;
   // value standing in for the undefined first capture
   localparam logic [15:0]  CAP_JUNK   = 16'hFFFF;

   // ------------------------------------------------------------------
   // mode encodings
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      TPQ_A_TIMER, TPQ_A_EVENT, TPQ_A_ONESHOT, TPQ_A_PWM
   } tpq_amode_e;

   typedef enum logic [1:0] {
      TPQ_B_TIMER, TPQ_B_EVENT, TPQ_B_MEAS
   } tpq_bmode_e;

   // ------------------------------------------------------------------
   // grouped control of the second timer
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        start;
      tpq_bmode_e  mode;
      logic        measWidth;    // 1 width, 0 period
      logic        wrEn;
      logic [15:0] wrData;
   } tpq_bctl_s;
endpackage

// [logic/tpq_sync.sv]
`timescale 1ns/100ps
// two flip-flop synchroniser for pin inputs
module tpq_sync #(
   parameter int W = 2
) (
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1Q;
   logic [W-1:0] s2Q;

   // ------------------------------------------------------------------
   // two stages
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s1Q <= '0;
         s2Q <= '0;
      end else if (ce) begin
         s1Q <= din;
         s2Q <= s1Q;
      end
   end
   assign dout = s2Q;
endmodule // tpq_sync

// [logic/tpq_timer.sv]
`timescale 1ns/100ps
// Summary of operation
// - PWM chosen after reset or from timer/event mode sets the A flag.
// - Clearing start while PWM output is high halts, drops it, sets flag.
// - Clearing start while PWM output is low halts, keeps it low, no flag.
// - B count reads give the live counter in timer and event modes.
// - A B count read at the reload moment returns all ones.
// - A B write while halted reads back until counting starts.
// - Changing period/width select after start in measure sets B flag.
// - First active edge after measure start loads an undefined value.
// - That first edge raises no B request.
module tpq_timer #(
   parameter int CW = tpq_pkg::CNT_W
) (
   input  wire logic                clk_sys,
   input  wire logic                resetn,
   input  wire logic                ce,
   input  wire logic                aStart,
   input  wire tpq_pkg::tpq_amode_e aMode,
   input  wire logic [CW-1:0]       aPeriod,
   input  wire logic [CW-1:0]       aHigh,
   input  wire logic                aFlagClr,
   input  wire tpq_pkg::tpq_bctl_s  bCtl,
   input  wire logic                bFlagClr,
   input  wire logic                eventPin,
   input  wire logic                measPin,
   output logic                     first_group_pulse_output,
   output logic                     aFlag,
   output logic                     bFlag,
   output logic [CW-1:0]            bCount,
   output logic [CW-1:0]            bReload
);
   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [1:0] pinS;
   tpq_sync #(.W(2)) uSync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .ce      (ce),
      .din     ({measPin, eventPin}),
      .dout    (pinS)
   );

   // ------------------------------------------------------------------
   // timer A state
   // ------------------------------------------------------------------
   logic [CW-1:0]       aCntQ, aCntD;
   logic                aOutQ, aOutD;
   logic                aFlagQ, aFlagD;
   logic                aStartQ;
   logic                aFirstQ, aFirstD;  // no mode seen since reset
   tpq_pkg::tpq_amode_e aModeQ;
   logic                aEnterPwm;

   // timer A next state
   always_comb begin
      aCntD  = aCntQ;
      aOutD  = aOutQ;
      aFlagD = aFlagQ;
      aFirstD = 1'b0;
      aEnterPwm = (aMode == tpq_pkg::TPQ_A_PWM) &&
                  (aFirstQ || aModeQ == tpq_pkg::TPQ_A_TIMER ||
                   aModeQ == tpq_pkg::TPQ_A_EVENT);
      if (aFlagClr)
         aFlagD = 1'b0;
      if (aMode == tpq_pkg::TPQ_A_PWM && aStart) begin
         if (aCntQ >= aPeriod - CW'(1)) begin
            aCntD = '0;
            aOutD = (aHigh != '0);
         end else begin
            aCntD = aCntQ + CW'(1);
            if (aCntQ + CW'(1) >= aHigh)
               aOutD = 1'b0;
         end
      end else if (aMode == tpq_pkg::TPQ_A_PWM && aStartQ) begin
         aCntD = '0;
         if (aOutQ)
            aFlagD = 1'b1;
         aOutD = 1'b0;
      end else if (!aStart) begin
         aOutD = 1'b0;
      end
      if (aEnterPwm && aModeQ != aMode || aFirstQ && aEnterPwm)
         aFlagD = 1'b1;
   end

   // timer A registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         aCntQ   <= CW'(tpq_pkg::CNT_RST);
         aOutQ   <= 1'b0;
         aFlagQ  <= 1'b0;
         aStartQ <= 1'b0;
         aFirstQ <= 1'b1;
         aModeQ  <= tpq_pkg::TPQ_A_TIMER;
      end else if (ce) begin
         aCntQ   <= aCntD;
         aOutQ   <= aOutD;
         aFlagQ  <= aFlagD;
         aStartQ <= aStart;
         aFirstQ <= aFirstD;
         aModeQ  <= aMode;
      end
   end

   // ------------------------------------------------------------------
   // timer B state
   // ------------------------------------------------------------------
   logic [CW-1:0] bCntQ, bCntD;
   logic [CW-1:0] bRldQ, bRldD;
   logic [CW-1:0] bRdQ, bRdD;
   logic          bFlagQ, bFlagD;
   logic          bStartQ;
   logic          bSelQ;
   logic          bFirstQ, bFirstD;   // waiting for first edge
   logic          evPrevQ, msPrevQ;
   logic          evRise, msEdge, bReloadNow;

   // timer B next state
   always_comb begin
      bCntD   = bCntQ;
      bRldD   = bRldQ;
      bFlagD  = bFlagQ;
      bFirstD = bFirstQ;
      evRise  = pinS[0] && !evPrevQ;
      msEdge  = bCtl.measWidth ? (pinS[1] != msPrevQ)
                               : (pinS[1] && !msPrevQ);
      bReloadNow = 1'b0;
      if (bFlagClr)
         bFlagD = 1'b0;
      if (bCtl.start && !bStartQ)
         bFirstD = 1'b1;
      if (!bCtl.start) begin
         if (bCtl.wrEn) begin
            bCntD = CW'(bCtl.wrData);
            bRldD = CW'(bCtl.wrData);
         end
      end else if (bCtl.mode == tpq_pkg::TPQ_B_MEAS) begin
         bCntD = bCntQ + CW'(1);
         if (msEdge) begin
            bCntD = '0;
            bFirstD = 1'b0;
            if (bFirstQ || (bCtl.start && !bStartQ)) begin
               bRldD = CW'(tpq_pkg::CAP_JUNK);
            end else begin
               bRldD  = bCntQ;
               bFlagD = 1'b1;
            end
         end
         if (bStartQ && bSelQ != bCtl.measWidth)
            bFlagD = 1'b1;
      end else if (bCtl.mode == tpq_pkg::TPQ_B_TIMER ||
                   (bCtl.mode == tpq_pkg::TPQ_B_EVENT && evRise)) begin
         if (bCntQ == '0) begin
            bReloadNow = 1'b1;
            bCntD  = bRldQ;
            bFlagD = 1'b1;
         end else begin
            bCntD = bCntQ - CW'(1);
         end
      end
      // read port: live count, all ones at reload
      bRdD = bReloadNow ? CW'(tpq_pkg::CNT_ALL1) : bCntD;
   end

   // timer B registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bCntQ   <= CW'(tpq_pkg::CNT_RST);
         bRldQ   <= CW'(tpq_pkg::RELOAD_RST);
         bRdQ    <= CW'(tpq_pkg::CNT_RST);
         bFlagQ  <= 1'b0;
         bStartQ <= 1'b0;
         bSelQ   <= 1'b0;
         bFirstQ <= 1'b0;
         evPrevQ <= 1'b0;
         msPrevQ <= 1'b0;
      end else if (ce) begin
         bCntQ   <= bCntD;
         bRldQ   <= bRldD;
         bRdQ    <= bRdD;
         bFlagQ  <= bFlagD;
         bStartQ <= bCtl.start;
         bSelQ   <= bCtl.measWidth;
         bFirstQ <= bFirstD;
         evPrevQ <= pinS[0];
         msPrevQ <= pinS[1];
      end
   end

   // ------------------------------------------------------------------
   // outputs, all registered
   // ------------------------------------------------------------------
   assign first_group_pulse_output = aOutQ;
   assign aFlag   = aFlagQ;
   assign bFlag   = bFlagQ;
   assign bCount  = bRdQ;
   assign bReload = bRldQ;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   AST_PWM_HALT_HIGH: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ce && aMode == tpq_pkg::TPQ_A_PWM && aModeQ == tpq_pkg::TPQ_A_PWM &&
      aStartQ && !aStart && aOutQ |=> !aOutQ && aFlagQ)
      else $error("pwm halt from high did not drop output and flag");
   AST_PWM_HALT_LOW: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ce && aMode == tpq_pkg::TPQ_A_PWM && aModeQ == tpq_pkg::TPQ_A_PWM &&
      aStartQ && !aStart && !aOutQ && !aFlagQ && !aFlagClr
      |=> !aOutQ && !aFlagQ)
      else $error("pwm halt from low changed output or flag");
   AST_PWM_ENTRY: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ce && aMode == tpq_pkg::TPQ_A_PWM &&
      (aModeQ == tpq_pkg::TPQ_A_TIMER || aModeQ == tpq_pkg::TPQ_A_EVENT)
      |=> aFlagQ)
      else $error("entering pwm did not set flag");
   AST_B_SEL_CHANGE: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ce && bCtl.start && bStartQ && bCtl.mode == tpq_pkg::TPQ_B_MEAS &&
      bSelQ != bCtl.measWidth |=> bFlagQ)
      else $error("select change did not set flag");
   AST_B_HALT_WRITE: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ce && !bCtl.start && bCtl.wrEn
      |=> bCount == $past(bCtl.wrData))
      else $error("halted write not read back");
   // first measured edge must load the stand-in value and keep the flag low
   AST_B_FIRST_EDGE: assert property (
      @(posedge clk_sys) disable iff (!resetn)
      ce && bCtl.start && bStartQ && bCtl.mode == tpq_pkg::TPQ_B_MEAS &&
      bFirstQ && msEdge && !bFlagQ && bSelQ == bCtl.measWidth
      |=> !bFlagQ && bReload == CW'(tpq_pkg::CAP_JUNK))
      else $error("first measured edge raised flag or kept old reload");
endmodule // tpq_timer

// [dv/tpq_pin_model.sv]
`timescale 1ns/100ps
// far-side pin driver: square wave on both pulse inputs
module tpq_pin_model (
   input  wire logic       clk_sys,
   input  wire logic       run,
   input  wire logic [7:0] halfPer,
   output logic            eventPin,
   output logic            measPin
);
   logic [7:0] cnt_q;
   // toggle every halfPer cycles while running, low otherwise
   always_ff @(posedge clk_sys) begin
      if (!run || cnt_q == halfPer - 8'h01) cnt_q <= 8'h00;
      else cnt_q <= cnt_q + 8'h01;
      if (!run) measPin <= 1'b0;
      else if (cnt_q == halfPer - 8'h01) measPin <= !measPin;
   end
   assign eventPin = measPin;
endmodule // tpq_pin_model

// [dv/testbench.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   n_mismatch++; $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
   logic                clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1;
   logic                aStart = 1'b0, aFlagClr = 1'b0;
   logic                bFlagClr = 1'b0, run = 1'b0;
   tpq_pkg::tpq_amode_e aMode = tpq_pkg::TPQ_A_TIMER;
   logic [15:0]         aPeriod = 16'h0008, aHigh = 16'h0003;
   tpq_pkg::tpq_bctl_s  bCtl = '0;
   logic [7:0]          halfPer = 8'h05;
   logic                eventPin, measPin, pwmOut, aFlag, bFlag, seen;
   logic [15:0]         bCount, bReload, v;
   int                  n_mismatch = 0, samples_checked = 0;
   int                  cycles = 0, k;
   tpq_timer tpq_timer_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
      .aStart(aStart), .aMode(aMode), .aPeriod(aPeriod), .aHigh(aHigh),
      .aFlagClr(aFlagClr), .bCtl(bCtl), .bFlagClr(bFlagClr),
      .eventPin(eventPin), .measPin(measPin),
      .first_group_pulse_output(pwmOut), .aFlag(aFlag), .bFlag(bFlag),
      .bCount(bCount), .bReload(bReload));
   tpq_pin_model tpq_pin_model_i (.clk_sys(clk_sys), .run(run),
      .halfPer(halfPer), .eventPin(eventPin), .measPin(measPin));
   // clock and hang limit
   always #5 clk_sys = !clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic clrFlags();
      aFlagClr = 1'b1;
      bFlagClr = 1'b1;
      cyc(1);
      aFlagClr = 1'b0;
      bFlagClr = 1'b0;
   endtask
   task automatic waitSig(ref logic s, input logic lvl);
      for (int i = 0; i < 300 && s !== lvl; i++) cyc(1);
   endtask
   // rising edges two half periods apart; count restarts at zero on the edge
   function automatic logic [15:0] measExp(logic [7:0] h);
      return {7'h00, h, 1'b0} - 16'h0001;
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      void'($urandom(91015));
      cyc(4);
      resetn = 1'b1;
      aMode = tpq_pkg::TPQ_A_PWM;
      cyc(1);
      `CHK(aFlag, 1'b1)
      for (int m = 0; m < 2; m++) begin
         aMode = tpq_pkg::tpq_amode_e'(m);
         cyc(1);
         clrFlags();
         `CHK(aFlag, 1'b0)
         aMode = tpq_pkg::TPQ_A_PWM;
         cyc(1);
         `CHK(aFlag, 1'b1)
      end
      aPeriod = 16'($urandom_range(13, 6));
      aHigh = 16'($urandom_range(4, 2));
      aStart = 1'b1;
      waitSig(pwmOut, 1'b1);
      k = 0;
      while (pwmOut === 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      `CHK(16'(k), aHigh)
      clrFlags();
      waitSig(pwmOut, 1'b1);
      aStart = 1'b0;
      cyc(1);
      `CHK({pwmOut, aFlag}, 2'b01)
      aStart = 1'b1;
      waitSig(pwmOut, 1'b1);
      waitSig(pwmOut, 1'b0);
      clrFlags();
      aStart = 1'b0;
      cyc(3);
      `CHK({pwmOut, aFlag}, 2'b00)
      v = 16'($urandom_range(40, 20));
      bCtl.wrData = v;
      bCtl.wrEn = 1'b1;
      cyc(1);
      bCtl.wrEn = 1'b0;
      cyc(2);
      `CHK(bCount, v)
      bCtl.start = 1'b1;
      cyc(3);
      v = bCount;
      cyc(1);
      `CHK(bCount, v - 16'h0001)
      ce = 1'b0;
      cyc(3);
      `CHK(bCount, v - 16'h0001)
      ce = 1'b1;
      seen = 1'b0;
      repeat (60) begin
         cyc(1);
         seen |= (bCount === tpq_pkg::CNT_ALL1);
      end
      `CHK(seen, 1'b1)
      `CHK(bFlag, 1'b1)
      bCtl = '0;
      bCtl.wrData = 16'h0100;
      bCtl.wrEn = 1'b1;
      bCtl.mode = tpq_pkg::TPQ_B_EVENT;
      cyc(1);
      bCtl.wrEn = 1'b0;
      bCtl.start = 1'b1;
      run = 1'b1;
      cyc(50);
      `CHK(bCount < 16'h0100 && bCount > 16'h00F0, 1'b1)
      run = 1'b0;
      bCtl.start = 1'b0;
      bCtl.mode = tpq_pkg::TPQ_B_MEAS;
      cyc(3);
      clrFlags();
      halfPer = 8'($urandom_range(9, 4));
      bCtl.start = 1'b1;
      run = 1'b1;
      waitSig(measPin, 1'b1);
      cyc(4);
      `CHK(bReload, tpq_pkg::CAP_JUNK)
      `CHK(bFlag, 1'b0)
      waitSig(bFlag, 1'b1);
      `CHK(bReload, measExp(halfPer))
      clrFlags();
      bCtl.measWidth = 1'b1;
      cyc(1);
      `CHK(bFlag, 1'b1)
      run = 1'b0;
      final_report();
   end
endmodule // testbench
